// ==== rtl/aor_regs.sv ====
// Add-on side operation registers: FIFO port, bus-master addresses, pass-thru, mailbox status
//
// Behaviour
// [R1] FIFO port reads inbound, writes outbound storage
// [R2] Pins show inbound data and outbound space
// [R3] DMA logic treats 64-bit conversions as pairs; the pins here show single words, and pairing is left to the user
// [R4] Master address registers need add-on mastering enabled
// [R5] Write address register holds PCI write address
// [R6] Read address register holds PCI read address
// [R7] Address counters span bits 31:2, low zero
// [R8] Software starts transfers on word boundaries
// [R9] Write address advances to next unwritten location
// [R10] Read address advances to next unread location
// [R11] Address reads during transfer give progress
// [R12] Master address phase drives low bits zero
// [R13] Decoder hit captures address, asserts attention
// [R14] Pending pass-thru cycle inserts PCI wait states
// [R15] Add-on completes pass-thru via data register
// [R16] Status: outgoing upper half, incoming lower half
// [R17] Status bit one means written, not read
// [R18] Bit index is 4*(n-1)+b per half
// [R19] Incoming PCI to add-on, outgoing reverse
// [R20] Access needs chip select with a strobe
// [R21] Incoming mailboxes are read-only from add-on
// [R22] Source write sets bit, destination read clears
// [R23] Attention drops on completion or abort
`timescale 1ns/1ps
`include "aor_defs.svh"
module aor_regs (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Add-on register port
  input wire logic sel_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [5:0] addr_i,
  input wire logic [3:0] be_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o,
  input wire logic addon_master_en_i,
  // PCI side: FIFO halves
  input wire logic pci_fifo_we_i,
  input wire logic [31:0] pci_fifo_wdata_i,
  output logic pci_fifo_full_o,
  input wire logic pci_fifo_re_i,
  output logic [31:0] pci_fifo_rdata_o,
  output logic pci_fifo_empty_o,
  output logic inbound_data_available_pin_o,
  output logic outbound_space_available_pin_o,
  // PCI side: bus-master progress
  input wire logic bm_write_xfer_i,
  input wire logic bm_read_xfer_i,
  output logic [31:0] bm_write_addr_o,
  output logic [31:0] bm_read_addr_o,
  // PCI side: pass-thru target cycles
  input wire logic pt_hit_i,
  input wire logic pt_is_write_i,
  input wire logic [31:0] pt_addr_i,
  input wire logic [31:0] pt_wdata_i,
  input wire logic pt_abort_i,
  output logic pt_wait_o,
  output logic pt_done_o,
  output logic [31:0] pt_rdata_o,
  output logic passthru_attention_n_o,
  // PCI side: mailboxes
  input wire logic [3:0] pci_imb_we_i,
  input wire logic [1:0] pci_imb_sel_i,
  input wire logic [31:0] pci_imb_wdata_i,
  input wire logic [3:0] pci_omb_re_i,
  input wire logic [1:0] pci_omb_sel_i,
  output logic [31:0] pci_omb_rdata_o
);
  // ---------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------
  // Chip select with one strobe forms an access; a held strobe acts once, on its first cycle
  logic acc_rd, acc_wr, strobe_q, acc_first;
  assign acc_first = ~strobe_q;
  assign acc_rd = ~sel_n_i & ~rd_n_i & acc_first; // [R20]
  assign acc_wr = ~sel_n_i & ~wr_n_i & acc_first; // [R20]
  // Edge guard so a long strobe touches the FIFO or a flag once
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= ~sel_n_i & (~rd_n_i | ~wr_n_i);
    end
  end

  // Address compare used by every register except the mailboxes
  function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
    hit = (a == off);
  endfunction

  // Mailbox slot number from a word address within a bank
  function automatic logic [1:0] mb_slot(input logic [5:0] a);
    mb_slot = a[3:2];
  endfunction

  // ---------------------------------------------------------------
  // FIFO port
  // ---------------------------------------------------------------
  // Two separate directions, so a read never sees the last write
  logic [`AOR_FIFO_AW:0] in_wp_q, in_rp_q, out_wp_q, out_rp_q;
  logic in_empty, in_full, out_empty, out_full;
  logic [31:0] in_rdata, out_rdata;
  logic in_pop, out_push, in_push, out_pop;
  assign in_empty = (in_wp_q == in_rp_q);
  assign in_full = (in_wp_q == {~in_rp_q[`AOR_FIFO_AW], in_rp_q[`AOR_FIFO_AW-1:0]});
  assign out_empty = (out_wp_q == out_rp_q);
  assign out_full = (out_wp_q == {~out_rp_q[`AOR_FIFO_AW], out_rp_q[`AOR_FIFO_AW-1:0]});
  assign in_push = pci_fifo_we_i & ~in_full;
  assign in_pop = acc_rd & hit(addr_i, `AOR_OFF_FIFO) & ~in_empty; // [R1]
  assign out_push = acc_wr & hit(addr_i, `AOR_OFF_FIFO) & ~out_full; // [R1]
  assign out_pop = pci_fifo_re_i & ~out_empty;
  assign pci_fifo_full_o = in_full;
  assign pci_fifo_empty_o = out_empty;
  // Availability pins for external DMA; pairing for 64-bit conversion is the user's job
  assign inbound_data_available_pin_o = ~in_empty; // [R2]
  assign outbound_space_available_pin_o = ~out_full; // [R2] [R3]
  // Pointer update per direction; each pointer steps by its one-bit push or pop
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_wp_q <= '0;
      in_rp_q <= '0;
      out_wp_q <= '0;
      out_rp_q <= '0;
    end else begin
      in_wp_q <= in_wp_q + {{`AOR_FIFO_AW{1'b0}}, in_push};
      in_rp_q <= in_rp_q + {{`AOR_FIFO_AW{1'b0}}, in_pop};
      out_wp_q <= out_wp_q + {{`AOR_FIFO_AW{1'b0}}, out_push};
      out_rp_q <= out_rp_q + {{`AOR_FIFO_AW{1'b0}}, out_pop};
    end
  end

  // Inbound store: PCI fills, add-on drains
  aor_fifo_mem u_in_mem (
    .sys_clk_i(sys_clk_i),
    .we_i(in_push),
    .waddr_i(in_wp_q[`AOR_FIFO_AW-1:0]),
    .wdata_i(pci_fifo_wdata_i),
    .raddr_i(in_rp_q[`AOR_FIFO_AW-1:0]),
    .rdata_o(in_rdata)
  );

  // Outbound store: add-on fills, PCI drains
  aor_fifo_mem u_out_mem (
    .sys_clk_i(sys_clk_i),
    .we_i(out_push),
    .waddr_i(out_wp_q[`AOR_FIFO_AW-1:0]),
    .wdata_i(wdata_i),
    .raddr_i(out_rp_q[`AOR_FIFO_AW-1:0]),
    .rdata_o(out_rdata)
  );
  assign pci_fifo_rdata_o = out_rdata;

  // ---------------------------------------------------------------
  // Bus-master address counters
  // ---------------------------------------------------------------
  // Only bits 31:2 are stored; the low pair reads and drives zero
  logic [29:0] bm_wr_q, bm_rd_q;
  logic bm_acc_ok;
  assign bm_acc_ok = addon_master_en_i; // [R4]

  // Write address: loaded by add-on, advanced per word moved to PCI
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bm_wr_q <= `AOR_RST_BM_WRITE_ADDRESS;
    end else if (acc_wr & bm_acc_ok & hit(addr_i, `AOR_OFF_BM_WRITE_ADDRESS)) begin
      bm_wr_q <= wdata_i[31:2]; // [R5] [R7]
    end else if (bm_write_xfer_i) begin
      bm_wr_q <= bm_wr_q + 30'h00000001; // [R9]
    end
  end

  // Read address: loaded by add-on, advanced per word fetched from PCI
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bm_rd_q <= `AOR_RST_BM_READ_ADDRESS;
    end else if (acc_wr & bm_acc_ok & hit(addr_i, `AOR_OFF_BM_READ_ADDRESS)) begin
      bm_rd_q <= wdata_i[31:2]; // [R6] [R7]
    end else if (bm_read_xfer_i) begin
      bm_rd_q <= bm_rd_q + 30'h00000001; // [R10]
    end
  end
  // Address phase value: linear burst order, so bits 1:0 are zero
  assign bm_write_addr_o = {bm_wr_q, 2'b00}; // [R12]
  assign bm_read_addr_o = {bm_rd_q, 2'b00}; // [R12]

  // ---------------------------------------------------------------
  // Pass-thru
  // ---------------------------------------------------------------
  aor_pkg::aor_pt_state_t pt_state_q;
  logic [31:0] pt_addr_q, pt_data_q;
  logic pt_done_q, pt_add_rd, pt_add_wr;
  assign pt_add_rd = acc_rd & hit(addr_i, `AOR_OFF_PASSTHRU_DATA);
  assign pt_add_wr = acc_wr & hit(addr_i, `AOR_OFF_PASSTHRU_DATA);

  // Cycle tracker: abort outranks completion in the same cycle
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pt_state_q <= aor_pkg::AOR_PT_IDLE;
      pt_done_q <= 1'b0;
    end else begin
      pt_done_q <= 1'b0;
      unique case (pt_state_q)
        aor_pkg::AOR_PT_IDLE: begin
          if (pt_hit_i) begin
            pt_state_q <= pt_is_write_i ? aor_pkg::AOR_PT_WR : aor_pkg::AOR_PT_RD; // [R13]
          end
        end
        // Pending: a PCI write ends on an add-on read, a PCI read on an add-on write
        aor_pkg::AOR_PT_WR, aor_pkg::AOR_PT_RD: begin
          if (pt_abort_i) begin
            pt_state_q <= aor_pkg::AOR_PT_IDLE; // [R23]
          end else if ((pt_state_q == aor_pkg::AOR_PT_WR) ? pt_add_rd : pt_add_wr) begin
            pt_state_q <= aor_pkg::AOR_PT_IDLE; // [R15] [R23]
            pt_done_q <= 1'b1;
          end
        end
      endcase
    end
  end

  // Address and data capture; PCI write data is latched with the address
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pt_addr_q <= `AOR_RST_WORD;
      pt_data_q <= `AOR_RST_WORD;
    end else if (pt_state_q == aor_pkg::AOR_PT_IDLE && pt_hit_i) begin
      pt_addr_q <= pt_addr_i; // [R13]
      pt_data_q <= pt_wdata_i;
    end else if (pt_add_wr) begin
      pt_data_q <= wdata_i;
    end
  end
  // Wait states while a cycle is held for the add-on
  assign pt_wait_o = (pt_state_q != aor_pkg::AOR_PT_IDLE); // [R14]
  assign passthru_attention_n_o = (pt_state_q == aor_pkg::AOR_PT_IDLE); // [R13] [R23]
  assign pt_done_o = pt_done_q;
  assign pt_rdata_o = pt_data_q;

  // ---------------------------------------------------------------
  // Mailboxes and fill status
  // ---------------------------------------------------------------
  // Index n-1 is the slot, so bit 4*slot+byte matches the status layout
  logic [31:0] imb_q [0:3], omb_q [0:3];
  logic [15:0] in_fill_q, out_fill_q;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mb
      // Incoming data from PCI; add-on writes here are dropped
      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          imb_q[gi] <= `AOR_RST_WORD;
        end else if (pci_imb_sel_i == 2'(gi)) begin
          for (int b = 0; b < 4; b++) begin
            if (pci_imb_we_i[b]) begin
              imb_q[gi][8*b +: 8] <= pci_imb_wdata_i[8*b +: 8]; // [R19] [R21]
            end
          end
        end
      end
      // Outgoing data from add-on to PCI, byte-wise
      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          omb_q[gi] <= `AOR_RST_WORD;
        end else if (acc_wr && addr_i[5:4] == 2'b01 && mb_slot(addr_i) == 2'(gi)) begin
          for (int b = 0; b < 4; b++) begin
            if (be_i[b]) begin
              omb_q[gi][8*b +: 8] <= wdata_i[8*b +: 8]; // [R19]
            end
          end
        end
      end
      // Fill flags: a source write in the same cycle as the read wins
      for (genvar gb = 0; gb < 4; gb++) begin : g_byte
        always_ff @(posedge sys_clk_i or negedge resetn_i) begin
          if (!resetn_i) begin
            in_fill_q[4*gi+gb] <= 1'b0;
          end else if (pci_imb_we_i[gb] && pci_imb_sel_i == 2'(gi)) begin
            in_fill_q[4*gi+gb] <= 1'b1; // [R22]
          end else if (acc_rd && addr_i[5:4] == 2'b00 && mb_slot(addr_i) == 2'(gi) && be_i[gb]) begin
            in_fill_q[4*gi+gb] <= 1'b0; // [R22]
          end
        end
        always_ff @(posedge sys_clk_i or negedge resetn_i) begin
          if (!resetn_i) begin
            out_fill_q[4*gi+gb] <= 1'b0;
          end else if (acc_wr && addr_i[5:4] == 2'b01 && mb_slot(addr_i) == 2'(gi) && be_i[gb]) begin
            out_fill_q[4*gi+gb] <= 1'b1; // [R22]
          end else if (pci_omb_re_i[gb] && pci_omb_sel_i == 2'(gi)) begin
            out_fill_q[4*gi+gb] <= 1'b0; // [R22]
          end
        end
      end
    end
  endgenerate
  // PCI sees outgoing mailbox contents directly
  assign pci_omb_rdata_o = omb_q[pci_omb_sel_i];

  // ---------------------------------------------------------------
  // Read data mux
  // ---------------------------------------------------------------
  // FIFO reads come from the memory register one cycle after the pop
  logic fifo_rd_q;
  logic [31:0] rd_mux_q;

  // Register other read data at access time
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fifo_rd_q <= 1'b0;
      rd_mux_q <= `AOR_RST_WORD;
    end else begin
      fifo_rd_q <= in_pop;
      if (acc_rd) begin
        if (addr_i[5:4] == 2'b00) begin
          rd_mux_q <= imb_q[mb_slot(addr_i)];
        end else if (addr_i[5:4] == 2'b01) begin
          rd_mux_q <= omb_q[mb_slot(addr_i)];
        end else if (hit(addr_i, `AOR_OFF_BM_WRITE_ADDRESS) && bm_acc_ok) begin
          rd_mux_q <= {bm_wr_q, 2'b00}; // [R4] [R7] [R11]
        end else if (hit(addr_i, `AOR_OFF_BM_READ_ADDRESS) && bm_acc_ok) begin
          rd_mux_q <= {bm_rd_q, 2'b00}; // [R4] [R7] [R11]
        end else if (hit(addr_i, `AOR_OFF_PASSTHRU_ADDRESS)) begin
          rd_mux_q <= pt_addr_q;
        end else if (hit(addr_i, `AOR_OFF_PASSTHRU_DATA)) begin
          rd_mux_q <= pt_data_q;
        end else if (hit(addr_i, `AOR_OFF_MAILBOX_FILL_STATUS)) begin
          rd_mux_q <= {out_fill_q, in_fill_q}; // [R16] [R17] [R18]
        end else begin
          rd_mux_q <= `AOR_RST_WORD;
        end
      end
    end
  end
  assign rdata_o = fifo_rd_q ? in_rdata : rd_mux_q; // [R1]

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  attn_on_hit_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R13]
    (pt_state_q == aor_pkg::AOR_PT_IDLE && pt_hit_i) |=> !passthru_attention_n_o && pt_addr_q == $past(pt_addr_i))
    else $error("attention or address not taken on decoder hit");
  attn_drop_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R23]
    (!passthru_attention_n_o && pt_abort_i) |=> passthru_attention_n_o)
    else $error("attention kept after abort");
  wait_held_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R14]
    (pt_state_q == aor_pkg::AOR_PT_WR && !pt_abort_i && !pt_add_rd) |=> pt_wait_o)
    else $error("wait dropped before pass-thru completion");
  wr_addr_step_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R9]
    (bm_write_xfer_i && !acc_wr) |=> bm_write_addr_o == $past(bm_write_addr_o) + 32'h00000004)
    else $error("write address did not advance one word");
  rd_addr_step_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R10]
    (bm_read_xfer_i && !acc_wr) |=> bm_read_addr_o == $past(bm_read_addr_o) + 32'h00000004)
    else $error("read address did not advance one word");
  addr_low_zero_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R12]
    bm_write_addr_o[1:0] == 2'b00 && bm_read_addr_o[1:0] == 2'b00)
    else $error("master address low bits not zero");
  bm_locked_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R4]
    (!addon_master_en_i && !bm_write_xfer_i) |=> $stable(bm_wr_q))
    else $error("write address changed while add-on mastering off");
  fill_set_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R22]
    (pci_imb_we_i[0] && pci_imb_sel_i == 2'b00) |=> in_fill_q[0])
    else $error("incoming fill flag not set on PCI write");
  pins_track_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R2]
    in_push |=> inbound_data_available_pin_o)
    else $error("inbound pin not showing data after push");
endmodule

// ==== rtl/aor_defs.svh ====
// Offsets, field positions and reset values of the add-on operation registers
`ifndef AOR_DEFS_SVH
`define AOR_DEFS_SVH
`define AOR_OFF_IMB1 6'h00
`define AOR_OFF_OMB1 6'h10
`define AOR_OFF_FIFO 6'h20
`define AOR_OFF_BM_WRITE_ADDRESS 6'h24
`define AOR_OFF_PASSTHRU_ADDRESS 6'h28
`define AOR_OFF_PASSTHRU_DATA 6'h2C
`define AOR_OFF_BM_READ_ADDRESS 6'h30
`define AOR_OFF_MAILBOX_FILL_STATUS 6'h34
`define AOR_RST_BM_WRITE_ADDRESS 30'h00000000
`define AOR_RST_BM_READ_ADDRESS 30'h00000000
`define AOR_RST_FILL 16'h0000
`define AOR_RST_WORD 32'h00000000
`define AOR_OUT_HALF_LSB 16
`define AOR_FIFO_DEPTH 8
`define AOR_FIFO_AW 3
`endif

// ==== rtl/aor_pkg.sv ====
// Types shared by the add-on operation register block
package aor_pkg;
  // Pass-thru cycle state
  typedef enum logic [2:0] {
    AOR_PT_IDLE = 3'b001,
    AOR_PT_WR = 3'b010,
    AOR_PT_RD = 3'b100
  } aor_pt_state_t;
endpackage

// ==== rtl/aor_fifo_mem.sv ====
// Small word memory with registered read data, used by the FIFO directions
`timescale 1ns/1ps
`include "aor_defs.svh"
module aor_fifo_mem (
  input wire logic sys_clk_i,
  input wire logic we_i,
  input wire logic [`AOR_FIFO_AW-1:0] waddr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [`AOR_FIFO_AW-1:0] raddr_i,
  output logic [31:0] rdata_o
);
  // Storage array, no reset so it maps to plain RAM
  logic [31:0] mem_q [0:`AOR_FIFO_DEPTH-1];

  // Write port
  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // Registered read port
  always_ff @(posedge sys_clk_i) begin
    rdata_o <= mem_q[raddr_i];
  end
endmodule

// ==== bench/aor_partner.sv ====
// Add-on user logic model that drives the register strobes of the block
`timescale 1ns/1ps
module aor_partner (
  input wire logic sys_clk_i,
  output logic sel_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [5:0] addr_o,
  output logic [3:0] be_o,
  output logic [31:0] wdata_o,
  output logic rd_done_o
);
  // ----------------------------------------
  // Idle levels at time zero
  // ----------------------------------------
  initial begin
    sel_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    addr_o = 6'h3F;
    be_o = 4'h0;
    wdata_o = 32'h00000000;
    rd_done_o = 1'b0;
  end

  // ----------------------------------------
  // One access: strobe low for one edge, then a cycle high
  // ----------------------------------------
  task automatic access(input logic wr, input logic [5:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge sys_clk_i);
    #1;
    sel_n_o = 1'b0;
    rd_n_o = wr;
    wr_n_o = !wr;
    addr_o = a;
    be_o = b;
    wdata_o = d;
    @(posedge sys_clk_i);
    #1;
    // Released lines show a changed value so nothing leans on stale data
    sel_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    addr_o = ~a;
    wdata_o = ~d;
    rd_done_o = !wr; // Read data stands from here on
    @(posedge sys_clk_i);
    #1;
    rd_done_o = 1'b0;
  endtask
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the add-on operation register block
`timescale 1ns/1ps
`include "aor_defs.svh"
module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic sys_clk_i = 1'b0, resetn_i = 1'b0, men = 1'b0;
  logic sel_n, rd_n, wr_n, rd_done;
  logic [5:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata;
  logic f_we = 1'b0, f_re = 1'b0, f_full, f_empty, in_pin, out_pin;
  logic [31:0] f_wd = 32'h00000000, f_rd;
  logic bw_x = 1'b0, br_x = 1'b0;
  logic [31:0] bw_a, br_a;
  logic hit = 1'b0, hit_wr = 1'b0, abort = 1'b0, pwait, pdone, attn_n;
  logic [31:0] hit_a = 32'h00000000, hit_d = 32'h00000000, pt_rd;
  logic [3:0] imb_we = 4'h0, omb_re = 4'h0;
  logic [1:0] imb_sel = 2'h0, omb_sel = 2'h0;
  logic [31:0] imb_d = 32'h00000000, omb_d;
  int fail_count = 0, n_compared = 0, done_cnt = 0;
  logic [31:0] exp_q[$]; // Expected read data in request order

  always #5 sys_clk_i = ~sys_clk_i;

  aor_regs aor_regs_inst (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .sel_n_i(sel_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .addr_i(addr), .be_i(be), .wdata_i(wdata), .rdata_o(rdata), .addon_master_en_i(men),
    .pci_fifo_we_i(f_we), .pci_fifo_wdata_i(f_wd), .pci_fifo_full_o(f_full), .pci_fifo_re_i(f_re),
    .pci_fifo_rdata_o(f_rd), .pci_fifo_empty_o(f_empty), .inbound_data_available_pin_o(in_pin),
    .outbound_space_available_pin_o(out_pin), .bm_write_xfer_i(bw_x), .bm_read_xfer_i(br_x),
    .bm_write_addr_o(bw_a), .bm_read_addr_o(br_a), .pt_hit_i(hit), .pt_is_write_i(hit_wr),
    .pt_addr_i(hit_a), .pt_wdata_i(hit_d), .pt_abort_i(abort), .pt_wait_o(pwait), .pt_done_o(pdone),
    .pt_rdata_o(pt_rd), .passthru_attention_n_o(attn_n), .pci_imb_we_i(imb_we), .pci_imb_sel_i(imb_sel),
    .pci_imb_wdata_i(imb_d), .pci_omb_re_i(omb_re), .pci_omb_sel_i(omb_sel), .pci_omb_rdata_o(omb_d));

  aor_partner aor_partner_inst (.sys_clk_i(sys_clk_i), .sel_n_o(sel_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .addr_o(addr), .be_o(be), .wdata_o(wdata), .rd_done_o(rd_done));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    if (fail_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    aor_partner_inst.access(1'b0, a, 4'hF, 32'h00000000);
  endtask

  task automatic wr(input logic [5:0] a, input logic [3:0] b, input logic [31:0] d);
    aor_partner_inst.access(1'b1, a, b, d);
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  function automatic logic [31:0] bmask(input logic [3:0] b);
    return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction

  // Bus-master address: gated, aligned, advancing by one word per transfer
  task automatic bm_case(input logic rdir);
    logic [5:0] off;
    logic [31:0] a;
    off = rdir ? `AOR_OFF_BM_READ_ADDRESS : `AOR_OFF_BM_WRITE_ADDRESS;
    a = $urandom() & 32'hFFFFF000; // Transfers start on a word boundary
    men = 1'b0;
    wr(off, 4'hF, 32'h12345678);
    rd(off, 32'h00000000);
    men = 1'b1;
    rd(off, 32'h00000000);
    wr(off, 4'hF, a | 32'h00000003);
    rd(off, a);
    repeat (5) begin
      tick(1);
      if (rdir) br_x = 1'b1; else bw_x = 1'b1;
      tick(1);
      br_x = 1'b0;
      bw_x = 1'b0;
    end
    chk("bm_addr_o", rdir ? br_a : bw_a, a + 32'h14);
    rd(off, a + 32'h14);
    men = 1'b0;
    rd(off, 32'h00000000);
  endtask

  // Pass-thru hit from the PCI side, attention expected a cycle later
  task automatic pt_hit(input logic w);
    tick(1);
    hit = 1'b1;
    hit_wr = w;
    hit_a = $urandom();
    hit_d = $urandom();
    tick(1);
    hit = 1'b0;
    chk("attention_n", attn_n, 32'h0);
    chk("pt_wait", pwait, 32'h1);
  endtask

  // ----------------------------------------
  // Read watcher and completion-pulse counter
  // ----------------------------------------
  always @(posedge sys_clk_i) begin
    if (rd_done === 1'b1) begin
      chk("rdata_o", rdata, exp_q.size() > 0 ? exp_q.pop_front() : 32'hDEADBEEF);
    end
    if (pdone === 1'b1) begin
      done_cnt++;
    end
  end

  // Watchdog: a hung run is a failed run
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fail_count++;
    summarize();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] fw[8];
    logic [31:0] d, sa;
    logic [3:0] b;
    int k;
    k = $urandom(32'h32E9);
    tick(16);
    resetn_i = 1'b1;
    tick(1);
    chk("in_pin", in_pin, 32'h0);
    chk("out_pin", out_pin, 32'h1);
    chk("attention_n", attn_n, 32'h1);
    rd(`AOR_OFF_MAILBOX_FILL_STATUS, 32'h00000000);
    bm_case(1'b0);
    bm_case(1'b1);
    // Outbound FIFO: fill past full, then drain from the PCI side
    for (int i = 0; i < `AOR_FIFO_DEPTH + 1; i++) begin
      d = $urandom();
      if (i < `AOR_FIFO_DEPTH) fw[i] = d;
      wr(`AOR_OFF_FIFO, 4'hF, d);
    end
    chk("out_pin", out_pin, 32'h0);
    chk("fifo_empty", f_empty, 32'h0);
    for (int i = 0; i < `AOR_FIFO_DEPTH; i++) begin
      tick(2);
      chk("fifo_rdata", f_rd, fw[i]);
      f_re = 1'b1;
      tick(1);
      f_re = 1'b0;
    end
    tick(1);
    chk("fifo_empty", f_empty, 32'h1);
    chk("out_pin", out_pin, 32'h1);
    // Inbound FIFO: add-on reads what PCI pushed, not what it wrote
    // An even word count keeps pairs whole, as 64-bit conversion needs
    f_we = 1'b1;
    for (int i = 0; i < `AOR_FIFO_DEPTH; i++) begin
      fw[i] = $urandom();
      f_wd = fw[i];
      tick(1);
    end
    f_we = 1'b0;
    f_wd = ~f_wd;
    chk("in_pin", in_pin, 32'h1);
    chk("fifo_full", f_full, 32'h1);
    for (int i = 0; i < `AOR_FIFO_DEPTH; i++) begin
      rd(`AOR_OFF_FIFO, fw[i]);
    end
    chk("in_pin", in_pin, 32'h0);
    // Pass-thru: PCI write completed by reading data, PCI read by writing it
    k = done_cnt;
    pt_hit(1'b1);
    sa = hit_a;
    rd(`AOR_OFF_PASSTHRU_ADDRESS, sa);
    rd(`AOR_OFF_PASSTHRU_DATA, hit_d);
    chk("attention_n", attn_n, 32'h1);
    chk("done_count", 32'(done_cnt - k), 32'h1);
    pt_hit(1'b0);
    d = $urandom();
    wr(`AOR_OFF_PASSTHRU_DATA, 4'hF, d);
    chk("pt_rdata", pt_rd, d);
    chk("done_count", 32'(done_cnt - k), 32'h2);
    chk("pt_wait", pwait, 32'h0);
    pt_hit(1'b1);
    abort = 1'b1;
    tick(1);
    abort = 1'b0;
    chk("attention_n", attn_n, 32'h1);
    chk("pt_wait", pwait, 32'h0);
    chk("done_count", 32'(done_cnt - k), 32'h2);
    // Mailboxes: every box both ways, random byte set
    for (int m = 0; m < 4; m++) begin
      b = 4'($urandom_range(1, 15));
      d = $urandom();
      imb_we = b;
      imb_sel = 2'(m);
      imb_d = d;
      tick(1);
      imb_we = 4'h0;
      rd(`AOR_OFF_MAILBOX_FILL_STATUS, 32'(b) << (4 * m));
      wr(6'(`AOR_OFF_IMB1 + 4 * m), 4'hF, ~d);
      rd(6'(`AOR_OFF_IMB1 + 4 * m), d & bmask(b));
      rd(`AOR_OFF_MAILBOX_FILL_STATUS, 32'h00000000);
      wr(6'(`AOR_OFF_OMB1 + 4 * m), b, d);
      rd(`AOR_OFF_MAILBOX_FILL_STATUS, 32'(b) << (`AOR_OUT_HALF_LSB + 4 * m));
      omb_sel = 2'(m);
      tick(1);
      chk("omb_rdata", omb_d, d & bmask(b));
      omb_re = 4'hF;
      tick(1);
      omb_re = 4'h0;
      rd(`AOR_OFF_MAILBOX_FILL_STATUS, 32'h00000000);
    end
    tick(2);
    summarize();
  end
endmodule
